/* File: logic/tsense_core.sv */
// temperature sensor digital core: serial slave, registers, conversion scheduling and alert logic
//
// Behaviour
// [R1] pointer is 8 bits; only bits 1:0 are stored, upper bits read zero
// [R2] pointer 0 temperature, 1 settings, 2 lower limit, 3 upper limit
// [R3] settings and limits read/write; temperature result read-only, writes ignored
// [R4] 16-bit words travel upper byte first, then lower byte
// [R5] settings bits 3:0 and 14:13 read-only; bit 4 writable, host keeps default
// [R6] polarity clear: flag 1 until N faults above upper, 0 until N below lower
// [R7] polarity bit inverts the sense of the alert flag
// [R8] comparator mode: alert flag equals alert pin level
// [R9] rate field 7:6 selects 0.25, 1, 4, 8 conversions/s; reset 4/s
// [R10] temperature result changes only when a conversion completes
// [R11] conversion starts right after power-on without host command
// [R12] between conversions the core sits in low-power standby
// [R13] sleep bit 8 set stops periodic conversion immediately
// [R14] sleep entry done within 120 ms; first conversion after entry is slow
// [R15] host should start single shot with sleep write; normal times after 150 ms
// [R16] in sleep the serial interface still reads and writes all registers
// [R17] clearing sleep resumes continuous conversion at configured rate
// [R18] bit 9 selects comparator (0) or latched interrupt (1) alert mode
// [R19] comparator: alert active above upper, held until below lower
// [R20] interrupt mode: alert fires on each crossing of upper or lower limit
// [R21] polarity bit 10: alert pin active low at 0, active high at 1
// [R22] fault field 12:11 needs 1, 2, 4 or 6 consecutive qualifying conversions
// [R23] latched alert cleared by a read of any register or by sleep entry
// [R24] values are 12-bit two's complement in bits 15:4, bits 3:0 zero
// [R25] pointer persists across bus transactions
// [R26] settings reset to rate 10, bit 14 set, alert flag 1
`timescale 1ns/1ps
`include "tsense_defines.svh"

module tsense_core
  import tsense_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT,
  parameter int unsigned RATE_0_CYC = `RATE_0_CYC,
  parameter int unsigned RATE_1_CYC = `RATE_1_CYC,
  parameter int unsigned RATE_2_CYC = `RATE_2_CYC,
  parameter int unsigned RATE_3_CYC = `RATE_3_CYC,
  parameter int unsigned SLEEP_ENTRY_CYC = `SLEEP_ENTRY_CYC
) (
  input wire logic CLK_I, // core clock, 100 MHz
  input wire logic RST_N_I, // asynchronous reset, active low
  input wire logic SCL_I, // serial clock pin level
  input wire logic SDA_I, // serial data pin level
  output logic SDA_O, // serial data drive value, always low
  output logic SDA_OE_O, // high while the core pulls data low
  output logic ALERT_O, // alert pin level
  output logic CONV_RUN_O, // converter enable, high during a conversion
  output logic CONV_SLOW_O, // first conversion after sleep entry, slow timing
  input wire logic CONV_DONE_I, // converter result valid pulse
  input wire logic [11:0] CONV_DATA_I, // converter result, two's complement
  output logic STANDBY_O, // idle between periodic conversions
  output logic SHUTDOWN_O // sleep entry complete, minimum power
);

  // pin synchronisers
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'b111;
      {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'b111;
    end else begin
      {scl_s1_r, scl_s2_r, scl_s3_r} <= {SCL_I, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_s3_r} <= {SDA_I, sda_s1_r, sda_s2_r};
    end
  end

  wire scl_rise = scl_s2_r & ~scl_s3_r;
  wire scl_fall = ~scl_s2_r & scl_s3_r;
  wire bus_start = scl_s2_r & scl_s3_r & ~sda_s2_r & sda_s3_r;
  wire bus_stop = scl_s2_r & scl_s3_r & sda_s2_r & ~sda_s3_r;

  // registers
  ser_state_type ser_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] hold_r;
  logic [15:0] rd_word_r;
  logic byte_sel_r;
  logic rw_r;
  logic nack_r;
  logic sda_oe_r;
  logic [1:0] ptr_r;
  logic [15:0] cfg_r;
  logic [15:0] temp_r;
  logic [15:0] lower_r;
  logic [15:0] upper_r;

  function automatic logic [15:0] reg_read(input logic [1:0] p, input logic [15:0] cfg_view,
                                           input logic [15:0] t, input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [15:0] v;
    v = t;
    if (p == `PTR_OPERATING_SETTINGS) v = cfg_view;
    else if (p == `PTR_LOWER_LIMIT) v = lo;
    else if (p == `PTR_UPPER_LIMIT) v = hi;
    return v;
  endfunction

  function automatic logic [2:0] fault_need(input logic [1:0] code);
    logic [2:0] n;
    n = 3'h1;
    if (code == 2'h1) n = 3'h2;
    else if (code == 2'h2) n = 3'h4;
    else if (code == 2'h3) n = 3'h6;
    return n;
  endfunction

  // conversion and alert state
  logic busy_r, ss_busy_r, start_pend_r;
  logic [31:0] rate_cnt_r;
  logic [31:0] sleep_cnt_r;
  logic sleep_d_r, shutdown_r, slow_r;
  logic over_r, int_alert_r, alert_pin_r;
  logic [2:0] fault_cnt_r;

  wire sleep_on = cfg_r[`CFG_SLEEP_BIT];
  wire latch_mode = cfg_r[`CFG_LATCH_MODE_BIT];
  wire alert_polarity = cfg_r[`CFG_ALERT_POL_BIT];
  wire [1:0] rate_sel = cfg_r[`CFG_RATE_HI:`CFG_RATE_LO];
  wire [1:0] fault_sel = cfg_r[`CFG_FAULT_CNT_HI:`CFG_FAULT_CNT_LO];
  wire alert_flag = alert_polarity ? over_r : ~over_r; // [R6] [R7]
  wire [15:0] cfg_view = {ss_busy_r, cfg_r[14:6], alert_flag, cfg_r[4:0]};
  wire [15:0] rd_word = reg_read(ptr_r, cfg_view, temp_r, lower_r, upper_r); // [R2]

  // serial decode
  wire byte_full = (bit_cnt_r == `BITS_PER_BYTE);
  wire addr_hit = (shift_r[7:1] == DEV_ADDR);
  wire [2:0] tx_idx = 3'h7 - bit_cnt_r[2:0];
  wire [7:0] cur_byte = byte_sel_r ? rd_word_r[7:0] : rd_word_r[15:8]; // [R4]
  wire [7:0] nxt_byte = byte_sel_r ? rd_word_r[15:8] : rd_word_r[7:0];
  wire rx_state = (ser_r == SER_ADDR) || (ser_r == SER_PTR) || (ser_r == SER_WDAT);
  wire wr_stb = scl_fall & (ser_r == SER_WDAT) & byte_full & byte_sel_r;
  wire [15:0] wr_word = {hold_r, shift_r}; // [R4]
  wire rd_begin = scl_fall & (ser_r == SER_ADDR_ACK) & rw_r; // [R16]
  wire wr_cfg = wr_stb & (ptr_r == `PTR_OPERATING_SETTINGS);
  wire wr_low = wr_stb & (ptr_r == `PTR_LOWER_LIMIT);
  wire wr_high = wr_stb & (ptr_r == `PTR_UPPER_LIMIT);
  wire [15:0] cfg_wr_val = (cfg_r & ~`CFG_WRITE_MASK) | (wr_word & `CFG_WRITE_MASK); // [R5]

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ser_r <= SER_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      hold_r <= 8'h00;
      rd_word_r <= 16'h0000;
      byte_sel_r <= 1'b0;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      ptr_r <= `PTR_TEMPERATURE_RESULT;
    end else if (bus_start) begin
      ser_r <= SER_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      ser_r <= SER_IDLE;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      if (rx_state && !byte_full) begin
        shift_r <= {shift_r[6:0], sda_s2_r};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (ser_r == SER_RDAT) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else if (ser_r == SER_RDAT_ACK) begin
        nack_r <= sda_s2_r;
      end
    end else if (scl_fall) begin
      case (ser_r)
        SER_ADDR: begin
          if (byte_full) begin
            if (addr_hit) begin
              ser_r <= SER_ADDR_ACK;
              rw_r <= shift_r[0];
              sda_oe_r <= 1'b1;
            end else begin
              ser_r <= SER_IDLE;
            end
          end
        end
        SER_ADDR_ACK: begin
          bit_cnt_r <= 4'h0;
          byte_sel_r <= 1'b0;
          if (rw_r) begin
            // snapshot so a conversion mid-read cannot tear the word
            rd_word_r <= rd_word;
            ser_r <= SER_RDAT;
            sda_oe_r <= ~rd_word[15];
          end else begin
            ser_r <= SER_PTR;
            sda_oe_r <= 1'b0;
          end
        end
        SER_PTR: begin
          if (byte_full) begin
            ptr_r <= shift_r[1:0]; // [R1] [R25]
            ser_r <= SER_PTR_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        SER_PTR_ACK: begin
          ser_r <= SER_WDAT;
          bit_cnt_r <= 4'h0;
          byte_sel_r <= 1'b0;
          sda_oe_r <= 1'b0;
        end
        SER_WDAT: begin
          if (byte_full) begin
            if (!byte_sel_r) hold_r <= shift_r;
            byte_sel_r <= ~byte_sel_r;
            ser_r <= SER_WDAT_ACK;
            sda_oe_r <= 1'b1;
          end
        end
        SER_WDAT_ACK: begin
          ser_r <= SER_WDAT;
          bit_cnt_r <= 4'h0;
          sda_oe_r <= 1'b0;
        end
        SER_RDAT: begin
          if (byte_full) begin
            ser_r <= SER_RDAT_ACK;
            sda_oe_r <= 1'b0;
          end else begin
            sda_oe_r <= ~cur_byte[tx_idx];
          end
        end
        SER_RDAT_ACK: begin
          if (nack_r) begin
            ser_r <= SER_IDLE;
            sda_oe_r <= 1'b0;
          end else begin
            byte_sel_r <= ~byte_sel_r;
            bit_cnt_r <= 4'h0;
            ser_r <= SER_RDAT;
            sda_oe_r <= ~nxt_byte[7];
          end
        end
        default: begin
          ser_r <= SER_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // host-writable registers
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_r <= `CFG_RESET; // [R26] [R9]
      lower_r <= `LOWER_LIMIT_RESET;
      upper_r <= `UPPER_LIMIT_RESET;
    end else begin
      if (wr_cfg) cfg_r <= {1'b0, cfg_wr_val[14:0]}; // [R3] [R13] [R17] [R18]
      if (wr_low) lower_r <= {wr_word[15:4], 4'h0}; // [R24]
      if (wr_high) upper_r <= {wr_word[15:4], 4'h0}; // [R24]
    end
  end

  // conversion scheduling
  wire ss_req = wr_cfg & wr_word[`CFG_SINGLE_SHOT_BIT] & wr_word[`CFG_SLEEP_BIT] & ~busy_r; // [R15]
  wire sleep_enter = sleep_on & ~sleep_d_r;
  wire sleep_leave = ~sleep_on & sleep_d_r;
  wire rate_due = ~sleep_on & (rate_cnt_r == 32'h0000_0000);
  wire conv_start = ~busy_r & (start_pend_r | rate_due | ss_req); // [R11]
  wire conv_done = busy_r & CONV_DONE_I;
  wire abort = busy_r & sleep_enter & ~ss_busy_r; // [R13]
  wire [31:0] rate_period = (rate_sel == 2'h0) ? RATE_0_CYC :
                            (rate_sel == 2'h1) ? RATE_1_CYC :
                            (rate_sel == 2'h2) ? RATE_2_CYC : RATE_3_CYC; // [R9]

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      busy_r <= 1'b0;
      ss_busy_r <= 1'b0;
      start_pend_r <= 1'b1;
      rate_cnt_r <= 32'h0000_0000;
      sleep_d_r <= 1'b0;
    end else begin
      sleep_d_r <= sleep_on;
      start_pend_r <= 1'b0;
      if (conv_start) begin
        busy_r <= 1'b1;
        ss_busy_r <= ss_req;
      end else if (conv_done || abort) begin
        busy_r <= 1'b0;
        ss_busy_r <= 1'b0;
      end
      if (sleep_leave) rate_cnt_r <= 32'h0000_0000; // [R17]
      else if (conv_start && !ss_req) rate_cnt_r <= rate_period - 32'h0000_0001;
      else if (!sleep_on && rate_cnt_r != 32'h0000_0000) rate_cnt_r <= rate_cnt_r - 32'h0000_0001; // [R12]
    end
  end

  // sleep entry timing
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sleep_cnt_r <= 32'h0000_0000;
      shutdown_r <= 1'b0;
      slow_r <= 1'b0;
    end else begin
      if (!sleep_on) begin
        sleep_cnt_r <= 32'h0000_0000;
        shutdown_r <= 1'b0;
      end else if (sleep_cnt_r < SLEEP_ENTRY_CYC - 1) begin
        sleep_cnt_r <= sleep_cnt_r + 32'h0000_0001;
      end else begin
        shutdown_r <= 1'b1; // [R14]
      end
      // first conversion after sleep entry runs on slow timing
      if (sleep_enter) slow_r <= 1'b1; // [R14]
      else if (conv_done) slow_r <= 1'b0;
    end
  end

  // result and alert
  wire signed [11:0] t_new = CONV_DATA_I;
  wire above = t_new >= $signed(upper_r[15:4]);
  wire below = t_new <= $signed(lower_r[15:4]);
  wire qualify = over_r ? below : above; // [R19]
  wire [2:0] fault_nxt = fault_cnt_r + 3'h1;
  wire flip = conv_done & qualify & (fault_nxt >= fault_need(fault_sel)); // [R22]
  wire alert_active = latch_mode ? int_alert_r : over_r; // [R18]

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      temp_r <= `TEMP_RESET;
      over_r <= 1'b0;
      fault_cnt_r <= 3'h0;
      int_alert_r <= 1'b0;
      alert_pin_r <= 1'b1;
    end else begin
      if (conv_done) temp_r <= {CONV_DATA_I, 4'h0}; // [R10] [R24]
      if (flip) begin
        over_r <= ~over_r; // [R6]
        fault_cnt_r <= 3'h0;
      end else if (conv_done) begin
        fault_cnt_r <= qualify ? fault_nxt : 3'h0;
      end
      // a crossing in the same cycle as a clearing read wins
      if (flip && latch_mode) int_alert_r <= 1'b1; // [R20]
      else if (rd_begin || sleep_enter || !latch_mode) int_alert_r <= 1'b0; // [R23]
      alert_pin_r <= alert_polarity ? alert_active : ~alert_active; // [R21] [R8]
    end
  end

  assign SDA_O = 1'b0;
  assign SDA_OE_O = sda_oe_r;
  assign ALERT_O = alert_pin_r;
  assign CONV_RUN_O = busy_r;
  assign CONV_SLOW_O = slow_r;
  assign STANDBY_O = ~busy_r & ~sleep_on; // [R12]
  assign SHUTDOWN_O = shutdown_r;

endmodule // tsense_core

/* File: logic/tsense_defines.svh */
// offsets, field positions, reset values and timing counts of the temperature sensor core
`ifndef TSENSE_DEFINES_SVH
`define TSENSE_DEFINES_SVH

// register pointer values
`define PTR_TEMPERATURE_RESULT 2'h0
`define PTR_OPERATING_SETTINGS 2'h1
`define PTR_LOWER_LIMIT 2'h2
`define PTR_UPPER_LIMIT 2'h3

// operating_settings field positions
`define CFG_SINGLE_SHOT_BIT 15
`define CFG_FAULT_CNT_HI 12
`define CFG_FAULT_CNT_LO 11
`define CFG_ALERT_POL_BIT 10
`define CFG_LATCH_MODE_BIT 9
`define CFG_SLEEP_BIT 8
`define CFG_RATE_HI 7
`define CFG_RATE_LO 6
`define CFG_ALERT_FLAG_BIT 5

// bits that the host may change in operating_settings, and register reset values
`define CFG_WRITE_MASK 16'h9fd0
`define CFG_RESET 16'h40a0
`define LOWER_LIMIT_RESET 16'h4b00
`define UPPER_LIMIT_RESET 16'h5000
`define TEMP_RESET 16'h0000

// timing
`define CLK_HZ 100000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define RATE_0_MS 4000
`define RATE_1_MS 1000
`define RATE_2_MS 250
`define RATE_3_MS 125
`define SLEEP_ENTRY_MS 120
`define RATE_0_CYC (`RATE_0_MS * `CYC_PER_MS)
`define RATE_1_CYC (`RATE_1_MS * `CYC_PER_MS)
`define RATE_2_CYC (`RATE_2_MS * `CYC_PER_MS)
`define RATE_3_CYC (`RATE_3_MS * `CYC_PER_MS)
`define SLEEP_ENTRY_CYC (`SLEEP_ENTRY_MS * `CYC_PER_MS)

// serial bus
`define DEV_ADDR_DEFAULT 7'h48
`define BITS_PER_BYTE 4'h8

`endif

/* File: logic/tsense_pkg.sv */
// types shared by the temperature sensor core
package tsense_pkg;

  typedef enum logic [3:0] {
    SER_IDLE,
    SER_ADDR,
    SER_ADDR_ACK,
    SER_PTR,
    SER_PTR_ACK,
    SER_WDAT,
    SER_WDAT_ACK,
    SER_RDAT,
    SER_RDAT_ACK
  } ser_state_type;

endpackage

/* File: verif/tsense_props.sv */
// concurrent checks on the temperature sensor core ports
`timescale 1ns/1ps
module tsense_props #(
  parameter int unsigned RATE_0_CYC = 400,
  parameter int unsigned SLEEP_ENTRY_CYC = 50
) (
  input wire logic CLK_I, // core clock
  input wire logic RST_N_I, // async reset, active low
  input wire logic SCL_I, // serial clock pin
  input wire logic SDA_OE_O, // data pull-down enable
  input wire logic CONV_RUN_O, // converter enable
  input wire logic CONV_SLOW_O, // slow conversion flag
  input wire logic CONV_DONE_I, // converter done pulse
  input wire logic STANDBY_O, // idle between conversions
  input wire logic SHUTDOWN_O // sleep entry complete
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  int unsigned stby_cnt_r;
  int unsigned idle_cnt_r;
  // counters stand in for long repetitions the tools cannot unroll
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stby_cnt_r <= 0;
      idle_cnt_r <= 0;
    end else begin
      stby_cnt_r <= STANDBY_O ? stby_cnt_r + 1 : 0;
      idle_cnt_r <= (!STANDBY_O && !CONV_RUN_O) ? idle_cnt_r + 1 : 0;
    end
  end
  sequence conv_done_s;
    CONV_RUN_O && CONV_DONE_I;
  endsequence
  pwr_on_conv_a: assert property ($rose(RST_N_I) |=> CONV_RUN_O)
    else $error("no conversion after reset release");
  done_end_a: assert property (conv_done_s |=> !CONV_RUN_O)
    else $error("conversion kept running after done");
  slow_clear_a: assert property (conv_done_s ##0 CONV_SLOW_O |=> !CONV_SLOW_O)
    else $error("slow flag stayed after a finished conversion");
  run_stby_a: assert property (CONV_RUN_O |-> !STANDBY_O)
    else $error("standby during a conversion");
  stby_max_a: assert property (stby_cnt_r <= RATE_0_CYC + 1)
    else $error("standby longer than the slowest rate period");
  shut_bound_a: assert property (idle_cnt_r == SLEEP_ENTRY_CYC + 3 |-> SHUTDOWN_O)
    else $error("sleep entry not complete in time");
  wake_conv_a: assert property ($fell(SHUTDOWN_O) |-> ##[0:2] CONV_RUN_O)
    else $error("no conversion after leaving sleep");
  oe_scl_a: assert property ($rose(SDA_OE_O) |-> !SCL_I)
    else $error("data drive started while clock high");
endmodule // tsense_props

/* File: verif/tsense_host.sv */
// two-wire bus host model facing the sensor core
`timescale 1ns/1ps
`include "tsense_defines.svh"
module tsense_host (
  output logic scl_o, // serial clock, idles high
  output logic sda_low_o, // pulls data low while high
  input wire logic sda_i // resolved data line
);
  localparam realtime Q = 31.25; // quarter of a 125 ns bit
  int nacks;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    nacks = 0;
  end
  // non-blocking so a pin change landing on a core clock edge cannot race the synchroniser
  task automatic bitx(input logic b, output logic r);
    #Q sda_low_o <= !b;
    #Q scl_o <= 1'b1;
    #Q r = sda_i;
    #Q scl_o <= 1'b0;
  endtask
  // m is the ninth bit sent; chk counts a missing slave ack
  task automatic xbyte(input logic [7:0] d, input logic m, input logic chk, output logic [7:0] r);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(m, a);
    if (chk && a) nacks++;
  endtask
  task automatic start();
    #Q sda_low_o <= 1'b1;
    #Q scl_o <= 1'b0;
  endtask
  task automatic stop();
    #Q sda_low_o <= 1'b1;
    #Q scl_o <= 1'b1;
    #Q sda_low_o <= 1'b0;
    #(4 * Q);
  endtask
  // pointer byte then, if nd, one word upper byte first
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input logic nd);
    logic [7:0] r;
    start();
    xbyte({`DEV_ADDR_DEFAULT, 1'b0}, 1'b1, 1'b1, r);
    xbyte(p, 1'b1, 1'b1, r);
    if (nd) begin
      xbyte(d[15:8], 1'b1, 1'b1, r);
      xbyte(d[7:0], 1'b1, 1'b1, r);
    end
    stop();
  endtask
  task automatic rd(output logic [15:0] d);
    logic [7:0] r;
    start();
    xbyte({`DEV_ADDR_DEFAULT, 1'b1}, 1'b1, 1'b1, r);
    xbyte(8'hff, 1'b0, 1'b0, d[15:8]);
    xbyte(8'hff, 1'b1, 1'b0, d[7:0]);
    stop();
  endtask
endmodule // tsense_host

/* File: verif/testbench.sv */
// self-checking bench for the temperature sensor core
`timescale 1ns/1ps
`define CHK(s, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %h, seen %h", s, e, g); end end
module testbench;
  localparam int SLP = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic conv_done = 1'b0;
  logic [11:0] conv_data = 12'h000;
  logic scl, host_low, sda, sda_drv, oe, alert, run, slow, stby, shut;
  logic [15:0] rv;
  int n_errors = 0;
  int n_tests = 0;
  int cc = 0;
  always #5 clk = ~clk;
  assign sda = !(host_low || (oe && !sda_drv));
  tsense_host i_host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
  tsense_core #(.RATE_0_CYC(400), .RATE_1_CYC(100), .RATE_2_CYC(40), .RATE_3_CYC(20),
    .SLEEP_ENTRY_CYC(SLP)) i_dut (.CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
    .SDA_O(sda_drv), .SDA_OE_O(oe), .ALERT_O(alert), .CONV_RUN_O(run), .CONV_SLOW_O(slow),
    .CONV_DONE_I(conv_done), .CONV_DATA_I(conv_data), .STANDBY_O(stby), .SHUTDOWN_O(shut));
  // converter: answers six cycles after each start
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (!run) cc <= 0;
    else if (cc == 5) begin
      conv_done <= 1'b1;
      cc <= 6;
    end else if (cc < 5) cc <= cc + 1;
  end
  task automatic summarize();
    if (n_errors == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic set_t(input logic [11:0] t);
    @(posedge clk);
    conv_data <= t;
  endtask
  task automatic wait_done(input int n);
    int t;
    t = 0;
    while (n > 0) begin
      @(posedge clk);
      t++;
      if (conv_done) n--;
      if (t > 5000) begin
        n_errors++;
        summarize();
      end
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] p, input logic [15:0] e, input string s);
    i_host.wr(p, 16'h0000, 1'b0);
    i_host.rd(rv);
    `CHK(s, e, rv)
  endtask
  // done-to-done spacing once the new rate has loaded; e is the period in cycles
  task automatic period(input logic [1:0] code, input int e);
    int t;
    t = 0;
    i_host.wr(8'h01, {8'h00, code, 6'h00}, 1'b1);
    wait_done(2);
    while (!conv_done && t < 1000) begin
      @(posedge clk);
      t++;
    end
    `CHK("conversion period", e, t + 4)
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h01, 16'h40a0, "settings default");
    rc(8'h02, 16'h4b00, "lower default");
    rc(8'h03, 16'h5000, "upper default");
    rc(8'h00, 16'h0000, "temperature default");
    rc(8'hfd, 16'h40a0, "pointer low bits");
    i_host.wr(8'h01, 16'h78cf, 1'b1);
    rc(8'h01, 16'h58e0, "settings read-only bits");
    i_host.wr(8'h02, 16'h123f, 1'b1);
    rc(8'h02, 16'h1230, "lower low nibble");
    i_host.wr(8'h02, 16'h4b00, 1'b1);
    i_host.wr(8'h01, 16'h0080, 1'b1);
    set_t(12'h190);
    wait_done(1);
    rc(8'h00, 16'h1900, "temperature result");
    i_host.wr(8'h00, 16'h1234, 1'b1);
    rc(8'h00, 16'h1900, "temperature write");
    i_host.rd(rv);
    `CHK("pointer kept", 16'h1900, rv)
    for (int c = 0; c < 4; c++) begin
      i_host.wr(8'h01, {3'b000, c[1:0], 11'h080}, 1'b1);
      set_t(12'h520);
      wait_done(c == 0 ? 0 : (c == 1 ? 1 : (c == 2 ? 3 : 5)));
      if (c > 0) `CHK("alert before count", 1'b1, alert)
      wait_done(1);
      `CHK("alert above upper", 1'b0, alert)
      rc(8'h01, {3'b010, c[1:0], 11'h080}, "flag over");
      set_t(12'h400);
      wait_done(c == 0 ? 1 : (c == 1 ? 2 : (c == 2 ? 4 : 6)));
      `CHK("alert below lower", 1'b1, alert)
    end
    period(2'h0, 400);
    period(2'h1, 100);
    period(2'h3, 20);
    period(2'h2, 40);
    i_host.wr(8'h01, 16'h0480, 1'b1);
    `CHK("alert high polarity idle", 1'b0, alert)
    rc(8'h01, 16'h4480, "flag polarity");
    set_t(12'h520);
    wait_done(1);
    `CHK("alert high polarity", 1'b1, alert)
    rc(8'h01, 16'h44a0, "flag polarity over");
    i_host.wr(8'h01, 16'h0280, 1'b1);
    set_t(12'h400);
    wait_done(1);
    `CHK("latched alert low", 1'b0, alert)
    i_host.rd(rv);
    `CHK("latched alert read", 1'b1, alert)
    set_t(12'h520);
    wait_done(1);
    `CHK("latched alert high", 1'b0, alert)
    i_host.wr(8'h01, 16'h0380, 1'b1);
    repeat (SLP + 5) @(posedge clk);
    `CHK("sleep entered", 1'b1, shut)
    `CHK("sleep clears latch", 1'b1, alert)
    `CHK("slow after sleep entry", 1'b1, slow)
    `CHK("no standby in sleep", 1'b0, stby)
    repeat (200) @(posedge clk);
    `CHK("no conversion in sleep", 1'b0, run)
    rc(8'h03, 16'h5000, "upper in sleep");
    set_t(12'h4c0);
    i_host.wr(8'h01, 16'h8380, 1'b1);
    rc(8'h00, 16'h4c00, "single shot result");
    `CHK("slow after single shot", 1'b0, slow)
    i_host.wr(8'h01, 16'h0080, 1'b1);
    wait_done(1);
    `CHK("sleep left", 1'b0, shut)
    `CHK("standby between", 1'b1, stby)
    `CHK("bus acks", 0, i_host.nacks)
    summarize();
  end
endmodule // testbench
bind tsense_core tsense_props #(.RATE_0_CYC(RATE_0_CYC), .SLEEP_ENTRY_CYC(SLEEP_ENTRY_CYC)) i_props (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_OE_O(SDA_OE_O), .CONV_RUN_O(CONV_RUN_O),
  .CONV_SLOW_O(CONV_SLOW_O), .CONV_DONE_I(CONV_DONE_I), .STANDBY_O(STANDBY_O), .SHUTDOWN_O(SHUTDOWN_O));
